/* common/das_pkg.sv */
// das_pkg: register map, field codes and timing constants for the drive aux supervisor
`default_nettype none
package das_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFF_MODE     = 12'h000;
	localparam logic [11:0] OFF_SEGFREQ  = 12'h004;
	localparam logic [11:0] OFF_OVERMOD  = 12'h008;
	localparam logic [11:0] OFF_QSTOP    = 12'h00C;
	localparam logic [11:0] OFF_OCLEVEL  = 12'h010;
	localparam logic [11:0] OFF_OCDELAY  = 12'h014;
	localparam logic [11:0] OFF_VLIMIT   = 12'h018;
	localparam logic [11:0] OFF_STATUS   = 12'h01C;

	// ----------------------------------------
	// mode register field positions
	// ----------------------------------------
	localparam int MODE_FAN_LSB   = 0;
	localparam int MODE_SEG_BIT   = 2;
	localparam int MODE_DZ_LSB    = 4;
	localparam int MODE_JOG_BIT   = 6;
	localparam int MODE_TUNIT_LSB = 8;
	localparam int MODE_TERM_BIT  = 10;

	// ----------------------------------------
	// codes and reset values
	// ----------------------------------------
	localparam logic [1:0]  FAN_POWERON  = 2'h0;
	localparam logic [1:0]  FAN_RUN      = 2'h1;
	localparam logic [1:0]  FAN_TEMP     = 2'h2;
	localparam logic [1:0]  DZ_NONE      = 2'h0;
	localparam logic [1:0]  DZ_MODE1     = 2'h1;
	localparam logic [1:0]  DZ_MODE2     = 2'h2;
	localparam logic [1:0]  TUNIT_MAX    = 2'h2;
	localparam logic [31:0] RST_MODE     = 32'h0000_0011;
	localparam logic [15:0] RST_SEGFREQ  = 16'h05DC;   // 15.00 Hz in 0.01 Hz
	localparam logic [15:0] RST_OVERMOD  = 16'h0069;   // 1.05 in 0.01
	localparam logic [15:0] OVERMOD_MIN  = 16'h0064;   // 1.00
	localparam logic [15:0] OVERMOD_MAX  = 16'h006E;   // 1.10
	localparam logic [15:0] RST_QSTOP    = 16'h0064;   // 1.00 s
	localparam logic [15:0] RST_OCLEVEL  = 16'h07D0;   // 200.0 %
	localparam logic [15:0] OCLEVEL_MAX  = 16'h0BB8;   // 300.0 %
	localparam logic [15:0] RST_OCDELAY  = 16'h0000;   // 0.00 s
	localparam logic [15:0] OCDELAY_MAX  = 16'hEA60;   // 600.00 s
	localparam logic [7:0]  TEMP_ON_C    = 8'h2D;      // 45 C
	localparam logic [7:0]  TEMP_OFF_C   = 8'h28;      // 40 C
	localparam logic [7:0]  OUT_FUNC_OC  = 8'h49;      // function code 73

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ         = 10_000_000;
	localparam int FAN_STOP_S     = 60;        // 1 min run-on after stop
	localparam int TICK_MS        = 10;        // delay unit 0.01 s
	localparam int TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
	localparam int FAN_STOP_TICKS = FAN_STOP_S * 1000 / TICK_MS;
endpackage
`default_nettype wire

/* core/das_top.sv */
// das_top: fan, pwm segment, dead-zone, jog gate and overcurrent supervisor
`default_nettype none

// Contract
// R1: mode 0 fan on from power-up
// R2: mode 1 fan on running, off 1 min
// R3: mode 2 on above 45, off below 40
// R4: switch option 0 forces seven-segment PWM
// R5: option 1 five-segment above switch frequency
// R6: switch frequency clamped to max frequency
// R7: voltage ceiling scaled by overmodulation gain
// R8: dead-zone selector codes 0, 1, 2
// R9: operator keeps mode 1 normally
// R10: jog priority lets jog override running
// R11: without priority no direct jog switch
// R12: quick-stop time range by time unit
// R13: overcurrent output after delay expires
// R14: level relative to rated, 0 disables
// R15: delay 0 to 600.00 s
// R16: fan modes 0..2, default 1
// R17: timer restarts when current drops
// R18: fan and segment change on clock
module das_top #(
	parameter int TICK_CYCLES    = das_pkg::TICK_CYC,
	parameter int FAN_STOP_COUNT = das_pkg::FAN_STOP_TICKS
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [11:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// drive state from the control core
	input  wire logic        RUNNING,
	input  wire logic        JOG_REQ,
	input  wire logic        RUN_REQ,
	input  wire logic [15:0] OUT_FREQ,
	input  wire logic [15:0] MAX_OUT_FREQ,
	input  wire logic [15:0] VOLT_BASE,
	input  wire logic [15:0] MOTOR_CUR_PCT,
	// temperature sensor, whole degrees C
	input  wire logic [7:0]  HEATSINK_TEMP,
	// outputs to the power stage
	output logic             FAN_ON,
	output logic             SEG5_SEL,
	output logic      [1:0]  DZ_COMP_SEL,
	output logic      [15:0] VOLT_LIMIT,
	output logic      [15:0] QSTOP_TIME,
	output logic      [1:0]  QSTOP_UNIT,
	output logic             JOG_ACTIVE,
	output logic             OVERCUR_OUT
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [7:0]  temp_s1_r, temp_s2_r;
	logic        jog_s1_r, jog_s2_r;
	logic [7:0]  temp_s3_r;
	logic [7:0]  temp_ok_r;

	// sensor and jog terminal come from outside the clock domain
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			temp_s1_r <= 8'h00;
			temp_s2_r <= 8'h00;
			temp_s3_r <= 8'h00;
			jog_s1_r  <= 1'b0;
			jog_s2_r  <= 1'b0;
		end else begin
			temp_s1_r <= HEATSINK_TEMP;
			temp_s2_r <= temp_s1_r;
			temp_s3_r <= temp_s2_r;
			jog_s1_r  <= JOG_REQ;
			jog_s2_r  <= jog_s1_r;
		end
	end

	// a sensor word can be caught mid-change; take it once two samples agree
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			temp_ok_r <= 8'h00;
		else if (temp_s2_r == temp_s3_r)
			temp_ok_r <= temp_s3_r;
	end

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	logic [31:0] mode_r;
	logic [15:0] segfreq_r, overmod_r, qstop_r, oclevel_r, ocdelay_r;
	logic        wr_pend_r;
	logic [11:0] wr_addr_r;
	logic        rd_pend_r;
	logic [11:0] rd_addr_r;
	logic [31:0] rdata_nxt;
	wire         xfer_ok = HSEL && HREADY && HTRANS[1];
	wire  [15:0] wd16    = HWDATA[15:0];

	// range clamps on written values
	wire  [15:0] overmod_wr = (wd16 < das_pkg::OVERMOD_MIN) ? das_pkg::OVERMOD_MIN :
	                          (wd16 > das_pkg::OVERMOD_MAX) ? das_pkg::OVERMOD_MAX : wd16;
	wire  [15:0] oclevel_wr = (wd16 > das_pkg::OCLEVEL_MAX) ? das_pkg::OCLEVEL_MAX : wd16;
	// R15: delay capped at 600.00 s
	wire  [15:0] ocdelay_wr = (wd16 > das_pkg::OCDELAY_MAX) ? das_pkg::OCDELAY_MAX : wd16;
	// out-of-range codes fall back to the defaults
	wire  [1:0]  fan_wr  = (HWDATA[das_pkg::MODE_FAN_LSB +: 2] > das_pkg::FAN_TEMP) ?
	                       das_pkg::FAN_RUN : HWDATA[das_pkg::MODE_FAN_LSB +: 2];
	// R8: dead-zone selector holds only codes 0..2
	wire  [1:0]  dz_wr   = (HWDATA[das_pkg::MODE_DZ_LSB +: 2] > das_pkg::DZ_MODE2) ?
	                       das_pkg::DZ_MODE1 : HWDATA[das_pkg::MODE_DZ_LSB +: 2];
	wire  [1:0]  tu_wr   = (HWDATA[das_pkg::MODE_TUNIT_LSB +: 2] > das_pkg::TUNIT_MAX) ?
	                       2'h0 : HWDATA[das_pkg::MODE_TUNIT_LSB +: 2];
	wire  [31:0] mode_wr = {21'h000000, HWDATA[das_pkg::MODE_TERM_BIT], tu_wr,
	                        1'b0, HWDATA[das_pkg::MODE_JOG_BIT], dz_wr,
	                        1'b0, HWDATA[das_pkg::MODE_SEG_BIT], fan_wr};

	// address phase capture; every transfer is zero wait state
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			rd_addr_r <= 12'h000;
		end else begin
			wr_pend_r <= xfer_ok && HWRITE;
			rd_pend_r <= xfer_ok && !HWRITE;
			wr_addr_r <= HADDR;
			rd_addr_r <= HADDR;
		end
	end

	// R16: fan default code 1; R6: segment frequency default 15.00 Hz
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			mode_r    <= das_pkg::RST_MODE;
			segfreq_r <= das_pkg::RST_SEGFREQ;
			overmod_r <= das_pkg::RST_OVERMOD;
			qstop_r   <= das_pkg::RST_QSTOP;
			oclevel_r <= das_pkg::RST_OCLEVEL;
			ocdelay_r <= das_pkg::RST_OCDELAY;
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				das_pkg::OFF_MODE:    mode_r    <= mode_wr;
				das_pkg::OFF_SEGFREQ: segfreq_r <= wd16;
				das_pkg::OFF_OVERMOD: overmod_r <= overmod_wr;
				das_pkg::OFF_QSTOP:   qstop_r   <= wd16;
				das_pkg::OFF_OCLEVEL: oclevel_r <= oclevel_wr;
				das_pkg::OFF_OCDELAY: ocdelay_r <= ocdelay_wr;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// derived controls
	// ----------------------------------------
	wire  [1:0]  fan_mode   = mode_r[das_pkg::MODE_FAN_LSB +: 2];
	wire         seg_sw_en  = mode_r[das_pkg::MODE_SEG_BIT];
	wire         jog_first  = mode_r[das_pkg::MODE_JOG_BIT];
	wire         term_ctl   = mode_r[das_pkg::MODE_TERM_BIT];
	// R6: switch point never above the maximum output frequency
	wire  [15:0] seg_freq   = (segfreq_r > MAX_OUT_FREQ) ? MAX_OUT_FREQ : segfreq_r;
	// R7: ceiling = base * gain / 100, 1.10 gives +10 percent
	wire  [31:0] vprod      = VOLT_BASE * overmod_r;
	wire  [31:0] vscaled    = vprod / 32'h0000_0064;
	wire  [15:0] vlim_nxt   = (vscaled > 32'h0000_FFFF) ? 16'hFFFF : vscaled[15:0];

	// ----------------------------------------
	// fan control
	// ----------------------------------------
	logic        fan_r;
	logic [31:0] tick_cnt_r;
	logic [31:0] fan_hold_r;
	logic        fan_nxt;
	wire         tick      = (tick_cnt_r == 32'(TICK_CYCLES - 1));
	wire         hold_done = (fan_hold_r == 32'h0000_0000);

	// shared 0.01 s time base for fan run-on and overcurrent delay
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			tick_cnt_r <= 32'h0000_0000;
		else
			tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
	end

	// run-on counter reloads while running, counts down after stop
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			fan_hold_r <= 32'h0000_0000;
		else if (RUNNING)
			fan_hold_r <= 32'(FAN_STOP_COUNT);
		else if (tick && !hold_done)
			fan_hold_r <= fan_hold_r - 32'h0000_0001;
	end

	always_comb begin
		fan_nxt = fan_r;
		case (fan_mode)
			// R1: on from power-up and stays on
			das_pkg::FAN_POWERON: fan_nxt = 1'b1;
			// R2: on while running, off one minute after stop
			das_pkg::FAN_RUN:     fan_nxt = RUNNING || !hold_done;
			// R3: hysteresis, hold between 40 and 45 C
			das_pkg::FAN_TEMP: begin
				if (temp_ok_r > das_pkg::TEMP_ON_C)
					fan_nxt = 1'b1;
				else if (temp_ok_r < das_pkg::TEMP_OFF_C)
					fan_nxt = 1'b0;
			end
			default:              fan_nxt = 1'b1;
		endcase
	end

	// R18: fan and segment registered on the clock
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			fan_r      <= 1'b0;
			SEG5_SEL   <= 1'b0;
			VOLT_LIMIT <= 16'h0000;
		end else begin
			fan_r      <= fan_nxt;
			// R4: option off keeps seven-segment; R5: five above switch point
			SEG5_SEL   <= seg_sw_en && (OUT_FREQ > seg_freq);
			VOLT_LIMIT <= vlim_nxt;
		end
	end

	// ----------------------------------------
	// jog priority
	// ----------------------------------------
	logic jog_r;
	// R10: priority in terminal mode overrides running
	wire  jog_pref = term_ctl && jog_first && jog_s2_r;
	// R11: otherwise jog only entered from standstill
	wire  jog_idle = jog_s2_r && !RUN_REQ && (jog_r || !RUNNING);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			jog_r <= 1'b0;
		else
			jog_r <= jog_pref || jog_idle;
	end

	// ----------------------------------------
	// overcurrent detection
	// ----------------------------------------
	logic [15:0] oc_cnt_r;
	logic        oc_r;
	// R14: level 0.0 disables detection
	wire         oc_above = (oclevel_r != 16'h0000) && (MOTOR_CUR_PCT > oclevel_r);
	wire         oc_reach = (oc_cnt_r >= ocdelay_r);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			oc_cnt_r <= 16'h0000;
			oc_r     <= 1'b0;
		end else if (!oc_above) begin
			// R17: drop restarts timer and clears output
			oc_cnt_r <= 16'h0000;
			oc_r     <= 1'b0;
		end else begin
			if (tick && !oc_reach)
				oc_cnt_r <= oc_cnt_r + 16'h0001;
			// R13: assert once the delay has elapsed
			oc_r <= oc_reach;
		end
	end

	// ----------------------------------------
	// read mux and outputs
	// ----------------------------------------
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (rd_addr_r)
			das_pkg::OFF_MODE:    rdata_nxt = mode_r;
			das_pkg::OFF_SEGFREQ: rdata_nxt = {16'h0000, segfreq_r};
			das_pkg::OFF_OVERMOD: rdata_nxt = {16'h0000, overmod_r};
			das_pkg::OFF_QSTOP:   rdata_nxt = {16'h0000, qstop_r};
			das_pkg::OFF_OCLEVEL: rdata_nxt = {16'h0000, oclevel_r};
			das_pkg::OFF_OCDELAY: rdata_nxt = {16'h0000, ocdelay_r};
			das_pkg::OFF_VLIMIT:  rdata_nxt = {16'h0000, VOLT_LIMIT};
			das_pkg::OFF_STATUS:  rdata_nxt = {16'h0000, das_pkg::OUT_FUNC_OC,
			                                   3'h0, oc_r, jog_r, SEG5_SEL, 1'b0, fan_r};
			default:              rdata_nxt = 32'h0000_0000;
		endcase
	end

	// zero wait state, always OKAY
	assign HREADYOUT   = 1'b1;
	assign HRESP       = 1'b0;
	assign HRDATA      = rd_pend_r ? rdata_nxt : 32'h0000_0000;
	assign FAN_ON      = fan_r;
	assign DZ_COMP_SEL = mode_r[das_pkg::MODE_DZ_LSB +: 2];
	// R12: quick-stop value and its unit passed on together
	assign QSTOP_TIME  = qstop_r;
	assign QSTOP_UNIT  = mode_r[das_pkg::MODE_TUNIT_LSB +: 2];
	assign JOG_ACTIVE  = jog_r;
	assign OVERCUR_OUT = oc_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_fan_mode0_on: assert property (@(posedge CLK) disable iff (RST) // R1
		(fan_mode == das_pkg::FAN_POWERON) |=> FAN_ON)
		else $error("fan off in power-on mode");
	a_fan_run_on: assert property (@(posedge CLK) disable iff (RST) // R2
		(fan_mode == das_pkg::FAN_RUN && RUNNING) |=> FAN_ON)
		else $error("fan off while running");
	a_fan_hot_on: assert property (@(posedge CLK) disable iff (RST) // R3
		(fan_mode == das_pkg::FAN_TEMP && temp_ok_r > das_pkg::TEMP_ON_C) |=> FAN_ON)
		else $error("fan off above upper temperature");
	a_fan_cool_off: assert property (@(posedge CLK) disable iff (RST) // R3
		(fan_mode == das_pkg::FAN_TEMP && temp_ok_r < das_pkg::TEMP_OFF_C) |=> !FAN_ON)
		else $error("fan on below lower temperature");
	a_seg_seven: assert property (@(posedge CLK) disable iff (RST) // R4
		!seg_sw_en |=> !SEG5_SEL)
		else $error("five-segment with switching disabled");
	a_seg_five: assert property (@(posedge CLK) disable iff (RST) // R5
		(seg_sw_en && OUT_FREQ > seg_freq) |=> SEG5_SEL)
		else $error("seven-segment above switch point");
	a_dz_code_ok: assert property (@(posedge CLK) disable iff (RST) // R8
		DZ_COMP_SEL <= das_pkg::DZ_MODE2)
		else $error("dead-zone code out of range");
	a_jog_prio: assert property (@(posedge CLK) disable iff (RST) // R10
		(term_ctl && jog_first && jog_s2_r) |=> JOG_ACTIVE)
		else $error("jog priority ignored");
	a_jog_block: assert property (@(posedge CLK) disable iff (RST) // R11
		(!jog_first && RUN_REQ) |=> !JOG_ACTIVE)
		else $error("jog entered directly without priority");
	a_oc_disable: assert property (@(posedge CLK) disable iff (RST) // R14
		(oclevel_r == 16'h0000) |=> !OVERCUR_OUT)
		else $error("overcurrent flagged while disabled");
	a_oc_release: assert property (@(posedge CLK) disable iff (RST) // R17
		!oc_above |=> (!OVERCUR_OUT && oc_cnt_r == 16'h0000))
		else $error("overcurrent not released");
	a_oc_zero_dly: assert property (@(posedge CLK) disable iff (RST) // R13
		(oc_above && ocdelay_r == 16'h0000) ##1 oc_above |-> OVERCUR_OUT)
		else $error("zero-delay overcurrent late");
endmodule
`default_nettype wire

/* bench/das_plant.sv */
// das_plant: behavioural power stage, jog terminal and heatsink sensor
`default_nettype none
module das_plant (
	// commands from the bench
	input  wire logic        clk,
	input  wire logic        run_cmd,
	input  wire logic        jog_key,
	input  wire logic [7:0]  temp_c,
	input  wire logic [15:0] cur_pct,
	// plant state seen by the supervisor
	output var  logic        running,
	output var  logic        jog_term,
	output var  logic [7:0]  heatsink,
	output var  logic [15:0] motor_cur
);
	timeunit 1ns;
	timeprecision 1ns;

	// quiet plant at power-up
	initial begin
		running = 1'b0;
		motor_cur = 16'h0000;
	end

	// bridge state settles one cycle after the command
	always @(posedge clk) begin
		running <= run_cmd;
		motor_cur <= cur_pct;
	end

	// terminal and sensor are unclocked, so they move mid-cycle; idle levels at power-up
	initial begin
		jog_term = 1'b0;
		heatsink = 8'h00;
		forever begin
			@(jog_key, temp_c);
			#30;
			jog_term = jog_key;
			heatsink = temp_c;
		end
	end
endmodule
`default_nettype wire

/* bench/tb_drive_aux_supervisor.sv */
// tb_drive_aux_supervisor: self-checking bench for the aux supervisor
`default_nettype none
module tb_drive_aux_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK  = 4;
	localparam int STOPC = 5;
	localparam int LIMIT = 6000;
	localparam logic [11:0] RA [7] = '{das_pkg::OFF_MODE, das_pkg::OFF_SEGFREQ,
		das_pkg::OFF_OVERMOD, das_pkg::OFF_QSTOP, das_pkg::OFF_OCLEVEL,
		das_pkg::OFF_OCDELAY, 12'h020};
	localparam logic [15:0] RV [7] = '{16'h0011, das_pkg::RST_SEGFREQ, das_pkg::RST_OVERMOD,
		das_pkg::RST_QSTOP, das_pkg::RST_OCLEVEL, das_pkg::RST_OCDELAY, 16'h0000};
	localparam logic [7:0]  TEMPS [9] = '{8'h19, 8'h2E, 8'h2D, 8'h29, 8'h28, 8'h27, 8'h28,
		8'h2D, 8'h2E};
	localparam logic [8:0]  FANX = 9'h11E;
	localparam logic [15:0] OMW [3] = '{16'h006E, 16'h0078, 16'h0063};
	localparam logic [15:0] OMR [3] = '{16'h006E, 16'h006E, 16'h0064};
	typedef struct {string nm; logic [31:0] v;} das_note_s;

	logic        CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, RUN_REQ = 1'b0;
	logic [11:0] HADDR = 12'h000;
	logic [1:0]  HTRANS = 2'h0;
	logic [31:0] HWDATA = 32'h0, HRDATA;
	logic        HREADYOUT, HRESP, RUNNING, JOG_REQ, FAN_ON, SEG5_SEL, JOG_ACTIVE, OVERCUR_OUT;
	logic [15:0] OUT_FREQ = 16'h0000, MAX_OUT_FREQ = 16'h1388, VOLT_BASE = 16'h03E8;
	logic [15:0] MOTOR_CUR_PCT, cur_pct = 16'h0000, rnd = 16'h001F, f;
	logic [15:0] QSTOP_TIME;
	logic [1:0]  DZ_COMP_SEL, QSTOP_UNIT;
	logic [7:0]  HEATSINK_TEMP, temp_c = 8'h19;
	logic        run_cmd = 1'b0, jog_key = 1'b0, rd_dp = 1'b0;
	int          error_cnt = 0, samples_checked = 0, cyc = 0;
	das_note_s   note_q [$];
	das_note_s   note;

	always #50 CLK = ~CLK;

	das_top #(.TICK_CYCLES(TICK), .FAN_STOP_COUNT(STOPC)) uut (.CLK(CLK), .RST(RST),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .RUNNING(RUNNING), .JOG_REQ(JOG_REQ), .RUN_REQ(RUN_REQ),
		.OUT_FREQ(OUT_FREQ), .MAX_OUT_FREQ(MAX_OUT_FREQ), .VOLT_BASE(VOLT_BASE),
		.MOTOR_CUR_PCT(MOTOR_CUR_PCT), .HEATSINK_TEMP(HEATSINK_TEMP), .FAN_ON(FAN_ON),
		.SEG5_SEL(SEG5_SEL), .DZ_COMP_SEL(DZ_COMP_SEL), .VOLT_LIMIT(),
		.QSTOP_TIME(QSTOP_TIME), .QSTOP_UNIT(QSTOP_UNIT),
		.JOG_ACTIVE(JOG_ACTIVE), .OVERCUR_OUT(OVERCUR_OUT));

	das_plant plant (.clk(CLK), .run_cmd(run_cmd), .jog_key(jog_key), .temp_c(temp_c),
		.cur_pct(cur_pct), .running(RUNNING), .jog_term(JOG_REQ), .heatsink(HEATSINK_TEMP),
		.motor_cur(MOTOR_CUR_PCT));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [31:0] md(input logic [1:0] fan, input logic seg,
		input logic [1:0] dz, input logic jog, input logic [1:0] tu, input logic term);
		return {21'h000000, term, tu, 1'b0, jog, dz, 1'b0, seg, fan};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one single transfer; held until the slave is ready at each phase
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		HSEL <= 1'b1;
		HADDR <= a;
		HWRITE <= w;
		HTRANS <= 2'h2;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		note_q.push_back('{nm, e});
		bus(a, 1'b0, 32'h0);
	endtask

	task automatic st(input logic fan, seg, jog, oc, input string nm);
		rd(das_pkg::OFF_STATUS, {16'h0000, das_pkg::OUT_FUNC_OC, 3'h0, oc, jog, seg, 1'b0, fan},
			nm);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// monitor and watchdog
	// ----------------------------------------
	// read data is taken at the ready edge that closes its data phase
	always @(posedge CLK) begin
		if (rd_dp === 1'b1 && HREADYOUT === 1'b1) begin
			note = note_q.pop_front();
			check(note.nm, HRDATA, note.v);
			check("hresp", {31'h0, HRESP}, 32'h0);
		end
		if (HREADYOUT === 1'b1)
			rd_dp <= HSEL & HTRANS[1] & ~HWRITE;
	end

	// hang guard
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			error_cnt++;
			summarize();
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		bus(12'h020, 1'b1, 32'hFFFF_FFFF);
		foreach (RA[i]) rd(RA[i], {16'h0000, RV[i]}, "reset word");
		st(0, 0, 0, 0, "fan idle");
		run_cmd <= 1'b1;
		repeat (3) @(posedge CLK);
		st(1, 0, 0, 0, "fan run");
		run_cmd <= 1'b0;
		repeat (3) @(posedge CLK);
		st(1, 0, 0, 0, "fan run-on");
		repeat (STOPC * TICK + TICK + 4) @(posedge CLK);
		st(0, 0, 0, 0, "fan stopped");
		bus(das_pkg::OFF_MODE, 1'b1, md(das_pkg::FAN_POWERON, 0, das_pkg::DZ_MODE1, 0, 0, 0));
		repeat (2) @(posedge CLK);
		st(1, 0, 0, 0, "fan power-on");
		bus(das_pkg::OFF_MODE, 1'b1, md(das_pkg::FAN_TEMP, 0, das_pkg::DZ_MODE1, 0, 0, 0));
		for (int i = 0; i < 9; i++) begin
			temp_c <= TEMPS[i];
			repeat (6) @(posedge CLK);
			st(FANX[i], 0, 0, 0, "fan temp");
		end
		// segment choice, boundary then random frequencies
		bus(das_pkg::OFF_SEGFREQ, 1'b1, 32'h0000_03E8);
		OUT_FREQ <= 16'h0FA0;
		bus(das_pkg::OFF_MODE, 1'b1, md(das_pkg::FAN_POWERON, 0, das_pkg::DZ_MODE1, 0, 0, 0));
		repeat (2) @(posedge CLK);
		st(1, 0, 0, 0, "seg forced seven");
		bus(das_pkg::OFF_MODE, 1'b1, md(das_pkg::FAN_POWERON, 1, das_pkg::DZ_MODE1, 0, 0, 0));
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			f = (i < 2) ? 16'h03E8 + 16'(i) : {5'h00, rnd[10:0]};
			OUT_FREQ <= f;
			repeat (3) @(posedge CLK);
			st(1, f > 16'h03E8, 0, 0, "seg five");
		end
		MAX_OUT_FREQ <= 16'h0320;
		OUT_FREQ <= 16'h0384;
		repeat (3) @(posedge CLK);
		st(1, 1, 0, 0, "seg clamp");
		for (int i = 0; i < 3; i++) begin
			bus(das_pkg::OFF_OVERMOD, 1'b1, {16'h0000, OMW[i]});
			repeat (2) @(posedge CLK);
			rd(das_pkg::OFF_OVERMOD, {16'h0000, OMR[i]}, "overmod");
			rd(das_pkg::OFF_VLIMIT, 32'h3E8 * 32'(OMR[i]) / 32'h64, "volt limit");
		end
		// dead-zone and time-unit codes, spare code folded back
		for (int i = 0; i < 4; i++) begin
			bus(das_pkg::OFF_MODE, 1'b1, md(0, 0, 2'(i), 0, 2'(i), 0));
			rd(das_pkg::OFF_MODE, md(0, 0, (i == 3) ? 2'h1 : 2'(i), 0,
				(i == 3) ? 2'h0 : 2'(i), 0), "mode codes");
			check("dz sel", {30'h0, DZ_COMP_SEL}, (i == 3) ? 32'h1 : 32'(i));
			check("qstop unit", {30'h0, QSTOP_UNIT}, (i == 3) ? 32'h0 : 32'(i));
		end
		// operator settles on compensation mode 1 (last write above)
		bus(das_pkg::OFF_QSTOP, 1'b1, 32'h0000_FDE8);
		rd(das_pkg::OFF_QSTOP, 32'h0000_FDE8, "quick stop");
		check("qstop time", {16'h0000, QSTOP_TIME}, 32'h0000_FDE8);
		run_cmd <= 1'b1;
		RUN_REQ <= 1'b1;
		jog_key <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus(das_pkg::OFF_MODE, 1'b1, md(0, 0, 1, i != 1, 0, i != 2));
			repeat (5) @(posedge CLK);
			st(1, 0, i == 0, 0, "jog gate");
		end
		bus(das_pkg::OFF_OCLEVEL, 1'b1, 32'h0000_03E8);
		bus(das_pkg::OFF_OCDELAY, 1'b1, 32'h0000_0003);
		cur_pct <= 16'h05DC;
		repeat (4) @(posedge CLK);
		st(1, 0, 0, 0, "oc early");
		repeat (16) @(posedge CLK);
		st(1, 0, 0, 1, "oc late");
		cur_pct <= 16'h03E8;
		repeat (3) @(posedge CLK);
		st(1, 0, 0, 0, "oc drop");
		cur_pct <= 16'h05DC;
		repeat (4) @(posedge CLK);
		st(1, 0, 0, 0, "oc restart");
		bus(das_pkg::OFF_OCDELAY, 1'b1, 32'h0000_0000);
		repeat (3) @(posedge CLK);
		st(1, 0, 0, 1, "oc no delay");
		bus(das_pkg::OFF_OCLEVEL, 1'b1, 32'h0000_0000);
		repeat (3) @(posedge CLK);
		st(1, 0, 0, 0, "oc disabled");
		repeat (3) @(posedge CLK);
		summarize();
	end
endmodule
`default_nettype wire
